/* File: hdl/spm_pin_mux.sv */
// serial port pin multiplexer: two control registers and pin steering
// assumes the core data memory bus is synchronous to mclk, one access per cycle
//
// Summary of operation
// - one of two receive pins feeds port
// - select bit set: pin B feeds receive
// - select bit clear: pin A feeds receive
// - mode bit 5 enables uart emulation
// - uart mode ties receive data and sync
// - uart mode drives sync pin from flag
// - system control bit 10 selects alternate pins
// - alternate: receive pin flag in, tx flag out
// - alternate: receive sync pin is interrupt zero
// - alternate: transmit sync pin is interrupt one
// - serial clock stays serial clock always
// - unselected receive pin remains general-purpose
module spm_pin_mux (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic [13:0] dmAddr,
	input  wire logic [15:0] dmWrData,
	input  wire logic        dmWrEn,
	input  wire logic        dmRdEn,
	output logic      [15:0] dmRdData,
	output logic             dmRdValid,
	input  wire logic        rxPinAIn,
	output logic             rxPinAOut,
	output logic             rxPinAOe,
	input  wire logic        rxPinBIn,
	output logic             rxPinBOut,
	output logic             rxPinBOe,
	input  wire logic        rxFrameSyncIn,
	output logic             rxFrameSyncOut,
	output logic             rxFrameSyncOe,
	input  wire logic        txFrameSyncIn,
	output logic             txFrameSyncOut,
	output logic             txFrameSyncOe,
	output logic             txDataOut,
	output logic             txDataOe,
	input  wire logic        serialClockIn,
	output logic             serialClockOut,
	output logic             serialClockOe,
	input  wire logic        gpioAOut,
	input  wire logic        gpioAOe,
	output logic             gpioAIn,
	input  wire logic        gpioBOut,
	input  wire logic        gpioBOe,
	output logic             gpioBIn,
	input  wire logic        portRfsOut,
	input  wire logic        portRfsOe,
	input  wire logic        portTfsOut,
	input  wire logic        portTfsOe,
	input  wire logic        portTxData,
	input  wire logic        portTxOe,
	input  wire logic        portSclkOut,
	input  wire logic        portSclkOe,
	output logic             portSclkIn,
	output logic             portRxInput,
	output logic             portRxFrameSync,
	output logic             portTxFrameSync,
	input  wire logic        coreFlagOutOne,
	input  wire logic        flagOutput,
	output logic             flagInput,
	output logic             extInterruptZero,
	output logic             extInterruptOne
);

	logic [8:0]         modeControl_reg;
	logic [8:0]         modeControl_next;
	logic [15:0]        sysControl_reg;
	logic [15:0]        sysControl_next;
	logic [15:0]        rdData_reg;
	logic [15:0]        rdData_next;
	logic               rdValid_reg;
	logic               rdValid_next;
	spm_pkg::spm_ctrl_t ctrl;

	// register writes and reads
	always_comb begin
		modeControl_next = modeControl_reg;
		sysControl_next  = sysControl_reg;
		if (dmWrEn && dmAddr == spm_pkg::MODE_CONTROL_ADDR) begin
			modeControl_next = dmWrData[8:0];
		end
		if (dmWrEn && dmAddr == spm_pkg::SYS_CONTROL_ADDR) begin
			sysControl_next = dmWrData;
		end
		rdValid_next = dmRdEn;
		rdData_next  = 16'h0000;
		// unmapped addresses read as zero
		if (dmRdEn && dmAddr == spm_pkg::MODE_CONTROL_ADDR) begin
			rdData_next = {7'h00, modeControl_reg};
		end else if (dmRdEn && dmAddr == spm_pkg::SYS_CONTROL_ADDR) begin
			rdData_next = sysControl_reg;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			modeControl_reg <= spm_pkg::MODE_CONTROL_RST;
			sysControl_reg  <= spm_pkg::SYS_CONTROL_RST;
			rdData_reg      <= 16'h0000;
			rdValid_reg     <= 1'b0;
		end else begin
			modeControl_reg <= modeControl_next;
			sysControl_reg  <= sysControl_next;
			rdData_reg      <= rdData_next;
			rdValid_reg     <= rdValid_next;
		end
	end

	assign dmRdData  = rdData_reg;
	assign dmRdValid = rdValid_reg;

	// pin steering is combinational so it follows the registers one edge after a write
	assign ctrl.rxSelB    = modeControl_reg[spm_pkg::RX_SEL_BIT];
	assign ctrl.uartMode  = modeControl_reg[spm_pkg::UART_MODE_BIT];
	assign ctrl.altConfig = sysControl_reg[spm_pkg::ALT_CONFIG_BIT];

	// clock pin is never reassigned; gpio select for it is software's job
	assign serialClockOut = portSclkOut;
	assign serialClockOe  = portSclkOe;
	assign portSclkIn     = serialClockIn;

	// both receive pins always reach the gpio input side
	assign gpioAIn = rxPinAIn;
	assign gpioBIn = rxPinBIn;

	spm_route u_route (
		.ctrl             (ctrl),
		.rxPinAIn         (rxPinAIn),
		.rxPinBIn         (rxPinBIn),
		.rxFrameSyncIn    (rxFrameSyncIn),
		.txFrameSyncIn    (txFrameSyncIn),
		.gpioAOut         (gpioAOut),
		.gpioAOe          (gpioAOe),
		.gpioBOut         (gpioBOut),
		.gpioBOe          (gpioBOe),
		.portRfsOut       (portRfsOut),
		.portRfsOe        (portRfsOe),
		.portTfsOut       (portTfsOut),
		.portTfsOe        (portTfsOe),
		.portTxData       (portTxData),
		.portTxOe         (portTxOe),
		.coreFlagOutOne   (coreFlagOutOne),
		.flagOutput       (flagOutput),
		.rxPinAOut        (rxPinAOut),
		.rxPinAOe         (rxPinAOe),
		.rxPinBOut        (rxPinBOut),
		.rxPinBOe         (rxPinBOe),
		.rxFrameSyncOut   (rxFrameSyncOut),
		.rxFrameSyncOe    (rxFrameSyncOe),
		.txFrameSyncOut   (txFrameSyncOut),
		.txFrameSyncOe    (txFrameSyncOe),
		.txDataOut        (txDataOut),
		.txDataOe         (txDataOe),
		.portRxInput      (portRxInput),
		.portRxFrameSync  (portRxFrameSync),
		.portTxFrameSync  (portTxFrameSync),
		.flagInput        (flagInput),
		.extInterruptZero (extInterruptZero),
		.extInterruptOne  (extInterruptOne)
	);

endmodule

/* File: hdl/spm_pkg.sv */
// constants and types for the serial port pin multiplexer
// assumes a 14-bit word-addressed data memory bus with 16-bit data
package spm_pkg;

	localparam int          ADDR_W            = 14;
	localparam int          DATA_W            = 16;
	localparam int          MODE_W            = 9;

	localparam logic [13:0] MODE_CONTROL_ADDR = 14'h2015;
	localparam logic [13:0] SYS_CONTROL_ADDR  = 14'h3fff;

	localparam logic [8:0]  MODE_CONTROL_RST  = 9'h000;
	localparam logic [15:0] SYS_CONTROL_RST   = 16'h0000;

	localparam int          RX_SEL_BIT        = 4;
	localparam int          UART_MODE_BIT     = 5;
	localparam int          ALT_CONFIG_BIT    = 10;

	typedef struct packed {
		logic altConfig;
		logic uartMode;
		logic rxSelB;
	} spm_ctrl_t;

	// one two-way pin as seen from inside: input, output, output enable
	typedef struct packed {
		logic in;
		logic out;
		logic oe;
	} spm_pin_t;

endpackage

/* File: hdl/spm_route.sv */
// combinational steering of the serial port pins
// assumes control bits come from registers in the enclosing block
module spm_route (
	input  wire spm_pkg::spm_ctrl_t ctrl,
	input  wire logic               rxPinAIn,
	input  wire logic               rxPinBIn,
	input  wire logic               rxFrameSyncIn,
	input  wire logic               txFrameSyncIn,
	input  wire logic               gpioAOut,
	input  wire logic               gpioAOe,
	input  wire logic               gpioBOut,
	input  wire logic               gpioBOe,
	input  wire logic               portRfsOut,
	input  wire logic               portRfsOe,
	input  wire logic               portTfsOut,
	input  wire logic               portTfsOe,
	input  wire logic               portTxData,
	input  wire logic               portTxOe,
	input  wire logic               coreFlagOutOne,
	input  wire logic               flagOutput,
	output logic                    rxPinAOut,
	output logic                    rxPinAOe,
	output logic                    rxPinBOut,
	output logic                    rxPinBOe,
	output logic                    rxFrameSyncOut,
	output logic                    rxFrameSyncOe,
	output logic                    txFrameSyncOut,
	output logic                    txFrameSyncOe,
	output logic                    txDataOut,
	output logic                    txDataOe,
	output logic                    portRxInput,
	output logic                    portRxFrameSync,
	output logic                    portTxFrameSync,
	output logic                    flagInput,
	output logic                    extInterruptZero,
	output logic                    extInterruptOne
);

	logic selRx;

	always_comb begin
		selRx = ctrl.rxSelB ? rxPinBIn : rxPinAIn;

		// the unselected receive pin stays with the general-purpose logic
		rxPinAOut = gpioAOut;
		rxPinAOe  = ctrl.rxSelB ? gpioAOe : 1'b0;
		rxPinBOut = gpioBOut;
		rxPinBOe  = ctrl.rxSelB ? 1'b0 : gpioBOe;

		portRxInput = selRx;
		// uart emulation: frame sync sees the same line as receive data
		portRxFrameSync = ctrl.uartMode ? selRx : rxFrameSyncIn;

		if (ctrl.uartMode) begin
			rxFrameSyncOut = coreFlagOutOne;
			rxFrameSyncOe  = 1'b1;
		end else if (ctrl.altConfig) begin
			rxFrameSyncOut = 1'b0;
			rxFrameSyncOe  = 1'b0;
		end else begin
			rxFrameSyncOut = portRfsOut;
			rxFrameSyncOe  = portRfsOe;
		end

		portTxFrameSync = txFrameSyncIn;
		if (ctrl.altConfig) begin
			txFrameSyncOut = 1'b0;
			txFrameSyncOe  = 1'b0;
			txDataOut      = flagOutput;
			txDataOe       = 1'b1;
		end else begin
			txFrameSyncOut = portTfsOut;
			txFrameSyncOe  = portTfsOe;
			txDataOut      = portTxData;
			txDataOe       = portTxOe;
		end

		// interrupt and flag inputs are qualified by the alternate mode
		flagInput        = ctrl.altConfig & selRx;
		extInterruptZero = ctrl.altConfig & rxFrameSyncIn;
		extInterruptOne  = ctrl.altConfig & txFrameSyncIn;
	end

endmodule

/* File: sim/spm_partner.sv */
// far-side serial device: drives receive pins, frame syncs and serial clock
// assumes the bench raises frameOn while a frame is in progress
module spm_partner (
	input  wire logic       mclk,
	input  wire logic       frameOn,
	input  wire logic [3:0] bits,
	output logic            rxA,
	output logic            rxB,
	output logic            rfs,
	output logic            tfs,
	output logic            sclk
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		{rxA, rxB, rfs, tfs, sclk} = 5'h00;
	end
	always @(posedge mclk) begin
		// clock stands still between frames
		sclk <= frameOn & ~sclk;
		// released lines wander so a stale level never passes for data
		{rxA, rxB, rfs, tfs} <= frameOn ? bits : ~{rxA, rxB, rfs, tfs};
	end
endmodule

/* File: sim/spm_pin_mux_assertions.sv */
// checker for the serial port pin multiplexer
// assumes it is bound to spm_pin_mux and sees its ports only
module spm_pin_mux_assertions (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        dmWrEn,
	input wire logic        dmRdEn,
	input wire logic        dmRdValid,
	input wire logic [13:0] dmAddr,
	input wire logic [15:0] dmWrData,
	input wire logic        rxPinAIn,
	input wire logic        rxPinBIn,
	input wire logic        rxFrameSyncIn,
	input wire logic        txFrameSyncIn,
	input wire logic        serialClockIn,
	input wire logic        gpioAOe,
	input wire logic        rxPinAOe,
	input wire logic        coreFlagOutOne,
	input wire logic        flagOutput,
	input wire logic        rxFrameSyncOut,
	input wire logic        rxFrameSyncOe,
	input wire logic        txDataOut,
	input wire logic        txDataOe,
	input wire logic        portSclkIn,
	input wire logic        portRxInput,
	input wire logic        portRxFrameSync,
	input wire logic        flagInput,
	input wire logic        extInterruptZero,
	input wire logic        extInterruptOne
);
	logic selB, uart, alt;
	// shadow of the control bits so routing is judged every cycle
	always_ff @(posedge mclk) begin
		if (!rst_n)
			{alt, uart, selB} <= 3'h0;
		else if (dmWrEn && dmAddr == 14'h2015)
			{uart, selB} <= dmWrData[5:4];
		else if (dmWrEn && dmAddr == 14'h3fff)
			alt <= dmWrData[10];
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	rx_route_a: assert property (portRxInput == (selB ? rxPinBIn : rxPinAIn)) else $error("rx route");
	uart_tie_a: assert property (uart |-> portRxFrameSync == portRxInput) else $error("uart tie");
	uart_flag_a: assert property (uart |-> rxFrameSyncOe && rxFrameSyncOut == coreFlagOutOne) else $error("sync pin");
	flag_in_a: assert property (flagInput == (alt && portRxInput)) else $error("flag in");
	flag_out_a: assert property (alt |-> txDataOe && txDataOut == flagOutput) else $error("flag out");
	irq_zero_a: assert property (extInterruptZero == (alt && rxFrameSyncIn)) else $error("irq zero");
	irq_one_a: assert property (extInterruptOne == (alt && txFrameSyncIn)) else $error("irq one");
	sclk_keep_a: assert property (portSclkIn == serialClockIn) else $error("serial clock");
	free_pin_a: assert property (selB |-> rxPinAOe == gpioAOe) else $error("free pin");
	read_answer_a: assert property (dmRdEn |=> dmRdValid) else $error("read answer");
	cover property (uart && alt);
	cover property (selB && alt && rxPinBIn);
	cover property (dmRdEn ##1 dmRdValid);
endmodule
bind spm_pin_mux spm_pin_mux_assertions chk (.*);

/* File: sim/tb_serial_port_pin_mux.sv */
// self-checking bench for the serial port pin multiplexer
// assumes spm_pin_mux, its checker and spm_partner are compiled first
module tb_serial_port_pin_mux;
	timeunit 1ns;
	timeprecision 100ps;
	logic        mclk, rst_n, dmWrEn, dmRdEn, dmRdValid, frameOn, sel;
	logic [13:0] dmAddr;
	logic [15:0] dmWrData, dmRdData;
	logic [31:0] seed;
	logic [3:0]  bits;
	logic        rxPinAIn, rxPinAOut, rxPinAOe, rxPinBIn, rxPinBOut, rxPinBOe, rxFrameSyncIn, rxFrameSyncOut;
	logic        rxFrameSyncOe, txFrameSyncIn, txFrameSyncOut, txFrameSyncOe, txDataOut, txDataOe, serialClockIn;
	logic        serialClockOut, serialClockOe, gpioAOut, gpioAOe, gpioAIn, gpioBOut, gpioBOe, gpioBIn, portRfsOut;
	logic        portRfsOe, portTfsOut, portTfsOe, portTxData, portTxOe, portSclkOut, portSclkOe, portSclkIn;
	logic        portRxInput, portRxFrameSync, portTxFrameSync, coreFlagOutOne, flagOutput, flagInput;
	logic        extInterruptZero, extInterruptOne;
	int          failCount, nCompared, mode, sys;
	spm_pin_mux dut (.*);
	spm_partner far (.mclk(mclk), .frameOn(frameOn), .bits(bits), .rxA(rxPinAIn), .rxB(rxPinBIn),
		.rfs(rxFrameSyncIn), .tfs(txFrameSyncIn), .sclk(serialClockIn));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		nCompared++;
		if (seen !== exp) begin
			failCount++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [13:0] a, input logic [15:0] d);
		@(posedge mclk);
		dmWrEn <= 1'b1;
		dmAddr <= a;
		dmWrData <= d;
		@(posedge mclk);
		dmWrEn <= 1'b0;
		if (a == 14'h2015)
			mode = d & 16'h01ff;
		if (a == 14'h3fff)
			sys = d;
	endtask
	task automatic rd(input logic [13:0] a);
		@(posedge mclk);
		dmRdEn <= 1'b1;
		dmAddr <= a;
		@(posedge mclk);
		dmRdEn <= 1'b0;
		#1 chk("valid", {15'h0, dmRdValid}, 16'h1);
		chk("rdata", dmRdData, a == 14'h2015 ? mode[15:0] : a == 14'h3fff ? sys[15:0] : 16'h0);
		@(posedge mclk);
		#1 chk("valid end", {15'h0, dmRdValid}, 16'h0);
		chk("rdata end", dmRdData, 16'h0);
	endtask
	task automatic route(input int n);
		logic [15:0] e;
		repeat (n) begin
			@(posedge mclk);
			seed = xs(seed);
			{gpioAOut, gpioAOe, gpioBOut, gpioBOe, portRfsOut, portRfsOe, portTfsOut, portTfsOe} <= seed[7:0];
			{portTxData, portTxOe, portSclkOut, portSclkOe, coreFlagOutOne, flagOutput, frameOn} <= seed[14:8];
			bits <= seed[18:15];
			#1 sel = mode[4] ? rxPinBIn : rxPinAIn;
			e = {3'h0, sel, mode[5] ? sel : rxFrameSyncIn, sys[10] & sel, sys[10] & rxFrameSyncIn,
				sys[10] & txFrameSyncIn, sys[10] ? flagOutput : portTxData, sys[10] | portTxOe,
				mode[5] | (!sys[10] & portRfsOe), mode[5] ? coreFlagOutOne : !sys[10] & portRfsOut & portRfsOe,
				!sys[10] & portTfsOe, mode[4] & gpioAOe, !mode[4] & gpioBOe, serialClockIn};
			chk("route", {3'h0, portRxInput, portRxFrameSync, flagInput, extInterruptZero, extInterruptOne, txDataOut,
				txDataOe, rxFrameSyncOe, rxFrameSyncOut & rxFrameSyncOe, txFrameSyncOe, rxPinAOe, rxPinBOe,
				portSclkIn}, e);
			chk("pins", {8'h0, rxPinAOut & rxPinAOe, rxPinBOut & rxPinBOe, txFrameSyncOut & txFrameSyncOe,
				serialClockOut, serialClockOe, gpioAIn, gpioBIn, portTxFrameSync}, {8'h0, mode[4] & gpioAOut & gpioAOe,
				!mode[4] & gpioBOut & gpioBOe, !sys[10] & portTfsOut & portTfsOe, portSclkOut, portSclkOe, rxPinAIn,
				rxPinBIn, txFrameSyncIn});
		end
	endtask
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", nCompared, failCount);
		if (failCount == 0 && nCompared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	initial begin
		repeat (5000) @(posedge mclk);
		failCount++;
		tally_and_finish();
	end
	initial begin
		{rst_n, dmWrEn, dmRdEn, dmAddr, dmWrData, frameOn, bits} = '0;
		{gpioAOut, gpioAOe, gpioBOut, gpioBOe, portRfsOut, portRfsOe, portTfsOut, portTfsOe} = '0;
		{portTxData, portTxOe, portSclkOut, portSclkOe, coreFlagOutOne, flagOutput} = '0;
		seed = 32'h184994e9;
		{mode, sys, failCount, nCompared} = '0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		rd(14'h2015);
		rd(14'h3fff);
		for (int c = 0; c < 8; c++) begin
			seed = xs(seed);
			wr(14'h2015, {seed[15:6], c[1:0], seed[3:0]});
			wr(14'h3fff, {seed[31:27], c[2], seed[25:16]});
			route(25);
			wr(14'h2014, 16'hffff);
			rd(14'h2015);
			rd(14'h3fff);
			rd(14'h2014);
			$display("test cfg %0d done", c);
		end
		// mid-run reset must clear both control registers
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		{mode, sys} = '0;
		rd(14'h2015);
		rd(14'h3fff);
		route(10);
		$display("test reset done");
		tally_and_finish();
	end
endmodule
